// *** hw/etf_pkg.sv ***
// shared constants for the two-wire eeprom bus front end
package etf_pkg;
	localparam int          CLK_MHZ     = 20;
	localparam int          TWR_US      = 5000;
	localparam int          TWR_CYC     = TWR_US * CLK_MHZ;
	localparam int          TWR_W       = 17;
	localparam int          WORD_W      = 8;
	localparam int          STRAP_W     = 3;
	localparam logic [3:0]  DEV_TYPE    = 4'ha;
	localparam logic [3:0]  LAST_BIT    = 4'h7;
	localparam logic [3:0]  WORD_BITS   = 4'h8;
	localparam int          TYPE_HI     = 7;
	localparam int          TYPE_LO     = 4;
	localparam int          SEL_HI      = 3;
	localparam int          SEL_LO      = 1;

	typedef enum logic [2:0] {
		ETF_IDLE,
		ETF_ADDR,
		ETF_ACKW,
		ETF_ACK,
		ETF_WRX,
		ETF_RTX,
		ETF_RACK
	} etf_state_type;
endpackage : etf_pkg

// *** hw/etf_sync.sv ***
// two flip-flop level synchroniser, reset to zero
module etf_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rstn_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} etf_sync_type;

	etf_sync_type r;
	etf_sync_type next_r;

	always_comb begin
		next_r      = r;
		next_r.meta = d_i;
		next_r.sync = r.meta;
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign q_o = r.sync;
endmodule : etf_sync

// *** hw/etf_frontend.sv ***
// two-wire serial eeprom bus front end: link side and system side
// What this block does
// - data changes only while clock low; high-phase changes are conditions
// - falling data with clock high is a start
// - rising data with clock high is a stop
// - stop ending a read puts the device into standby
// - every transfer is an eight-bit word, one bit per clock
// - device pulls data low on the ninth clock after a matching address and each written word, not after read words
// - standby at power-up and after stop plus finished write cycle
// - address mismatch: no acknowledge, back to standby
// - eighth address bit high means read, low means write
// - during timed write cycle ignore inputs and never acknowledge
module etf_frontend
	import etf_pkg::*;
#(
	parameter int TWR_CYCLES = TWR_CYC
) (
	input  wire logic               mclk_i,
	input  wire logic               rstn_i,
	input  wire logic               link_clk_i,
	input  wire logic               scl_i,
	input  wire logic               sda_i,
	output logic                    sda_o,
	output logic                    sda_oe_o,
	input  wire logic [STRAP_W-1:0] chip_select_straps_i,
	input  wire logic [WORD_W-1:0]  tx_data_i,
	input  wire logic               tx_load_i,
	output logic      [WORD_W-1:0]  rx_data_o,
	output logic                    rx_valid_o,
	output logic                    busy_o,
	output logic                    standby_o
);
	typedef struct packed {
		logic               scl_q;
		logic               sda_q;
		etf_state_type      st;
		logic [3:0]         cnt;
		logic [WORD_W-1:0]  sh;
		logic               rw;
		logic               wseen;
		logic               wbusy;
		logic               busy_q;
		logic               wr_tgl;
		logic               rx_tgl;
		logic [WORD_W-1:0]  rx_hold;
		logic [WORD_W-1:0]  tx_word;
		logic               txt_q;
		logic               oe;
		logic               drv;
		logic               act;
	} etf_link_type;

	typedef struct packed {
		logic               wr_q;
		logic               rx_q;
		logic               busy;
		logic [TWR_W-1:0]   tcnt;
		logic [WORD_W-1:0]  rx_data;
		logic               rx_valid;
		logic               standby;
		logic [WORD_W-1:0]  tx_hold;
		logic               tx_tgl;
	} etf_sys_type;

	localparam logic [TWR_W-1:0] TWR_LAST = TWR_W'(TWR_CYCLES - 1);

	etf_link_type l;
	etf_link_type next_l;
	etf_sys_type  s;
	etf_sys_type  next_s;

	logic [1:0]         pins_s;
	logic [STRAP_W-1:0] straps_s;
	logic [1:0]         fromsys_s;
	logic [2:0]         fromlink_s;
	logic               scl_s;
	logic               sda_s;
	logic               busy_l;
	logic               txt_l;
	logic               start_w;
	logic               stop_w;
	logic               rise_w;
	logic               fall_w;
	logic               match_w;
	logic [WORD_W-1:0]  word_w;

	// pins cross into the link domain
	etf_sync #(.W(2)) u_pins (
		.clk_i  (link_clk_i),
		.rstn_i (rstn_i),
		.d_i    ({scl_i, sda_i}),
		.q_o    (pins_s)
	);
	etf_sync #(.W(STRAP_W)) u_straps (
		.clk_i  (link_clk_i),
		.rstn_i (rstn_i),
		.d_i    (chip_select_straps_i),
		.q_o    (straps_s)
	);
	etf_sync #(.W(2)) u_tolink (
		.clk_i  (link_clk_i),
		.rstn_i (rstn_i),
		.d_i    ({s.busy, s.tx_tgl}),
		.q_o    (fromsys_s)
	);
	// active flag resets low like its synchroniser: no standby dip at release
	etf_sync #(.W(3)) u_tosys (
		.clk_i  (mclk_i),
		.rstn_i (rstn_i),
		.d_i    ({l.wr_tgl, l.rx_tgl, l.act}),
		.q_o    (fromlink_s)
	);

	assign scl_s   = pins_s[1];
	assign sda_s   = pins_s[0];
	assign busy_l  = fromsys_s[1];
	assign txt_l   = fromsys_s[0];
	assign start_w = scl_s & l.scl_q & l.sda_q & ~sda_s;
	assign stop_w  = scl_s & l.scl_q & ~l.sda_q & sda_s;
	assign rise_w  = scl_s & ~l.scl_q;
	assign fall_w  = ~scl_s & l.scl_q;
	assign word_w  = {l.sh[WORD_W-2:0], sda_s};
	assign match_w = (word_w[TYPE_HI:TYPE_LO] == DEV_TYPE) &&
	                 (word_w[SEL_HI:SEL_LO] == straps_s);

	always_comb begin
		next_l       = l;
		next_l.scl_q = scl_s;
		next_l.sda_q = sda_s;
		next_l.busy_q = busy_l;
		next_l.drv   = 1'b0;
		// tx word is held stable by the system side after its toggle
		if (txt_l != l.txt_q) begin
			next_l.txt_q   = txt_l;
			next_l.tx_word = s.tx_hold;
		end
		// local busy covers the crossing latency of the timer
		if (l.busy_q && !busy_l) begin
			next_l.wbusy = 1'b0;
		end
		if (start_w || stop_w) begin
			// drop partial word on any condition
			next_l.cnt = 4'h0;
			next_l.oe  = 1'b0;
			next_l.st  = ETF_IDLE;
			if (stop_w && l.wseen) begin
				next_l.wr_tgl = ~l.wr_tgl;
				next_l.wbusy  = 1'b1;
			end
			next_l.wseen = 1'b0;
			// a start during the write cycle is not answered
			if (start_w && !l.wbusy) begin
				next_l.st = ETF_ADDR;
			end
		end else begin
			unique case (l.st)
				// idle ignores clocked bits until a start
				ETF_IDLE: begin
				end
				ETF_ADDR: begin
					if (rise_w) begin
						next_l.sh  = word_w;
						next_l.cnt = l.cnt + 4'h1;
						if (l.cnt == LAST_BIT) begin
							next_l.rw = sda_s;
							next_l.st = match_w ? ETF_ACKW : ETF_IDLE;
						end
					end
				end
				ETF_ACKW: begin
					// pull low for the ninth clock
					if (fall_w) begin
						next_l.oe = 1'b1;
						next_l.st = ETF_ACK;
					end
				end
				ETF_ACK: begin
					if (fall_w) begin
						next_l.cnt = 4'h0;
						if (l.rw) begin
							next_l.sh = l.tx_word;
							next_l.oe = ~l.tx_word[WORD_W-1];
							next_l.st = ETF_RTX;
						end else begin
							next_l.oe = 1'b0;
							next_l.st = ETF_WRX;
						end
					end
				end
				ETF_WRX: begin
					if (rise_w) begin
						next_l.sh  = word_w;
						next_l.cnt = l.cnt + 4'h1;
						if (l.cnt == LAST_BIT) begin
							next_l.rx_hold = word_w;
							next_l.rx_tgl  = ~l.rx_tgl;
							next_l.wseen   = 1'b1;
							next_l.st      = ETF_ACKW;
						end
					end
				end
				ETF_RTX: begin
					// output changes only after clock falls
					if (rise_w) begin
						next_l.cnt = l.cnt + 4'h1;
						if (l.cnt == LAST_BIT) begin
							next_l.st = ETF_RACK;
						end
					end else if (fall_w) begin
						next_l.sh = {l.sh[WORD_W-2:0], 1'b0};
						next_l.oe = ~l.sh[WORD_W-2];
					end
				end
				ETF_RACK: begin
					if (fall_w) begin
						next_l.oe = 1'b0;
					end else if (rise_w) begin
						next_l.st = sda_s ? ETF_IDLE : ETF_ACK;
					end
				end
			endcase
		end
		// stop or nack after read leaves the link idle
		next_l.act = (next_l.st != ETF_IDLE);
	end

	always_ff @(posedge link_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			l       <= '0;
			l.scl_q <= 1'b1;
			l.sda_q <= 1'b1;
			l.st    <= ETF_IDLE;
		end else begin
			l <= next_l;
		end
	end

	// system side: write cycle timer, word hand-off, standby
	always_comb begin
		next_s          = s;
		next_s.wr_q     = fromlink_s[2];
		next_s.rx_q     = fromlink_s[1];
		next_s.rx_valid = 1'b0;
		if (fromlink_s[1] != s.rx_q) begin
			next_s.rx_data  = l.rx_hold;
			next_s.rx_valid = 1'b1;
		end
		if (tx_load_i) begin
			next_s.tx_hold = tx_data_i;
			next_s.tx_tgl  = ~s.tx_tgl;
		end
		// timed write cycle after a write stop
		if (fromlink_s[2] != s.wr_q) begin
			next_s.busy = 1'b1;
			next_s.tcnt = '0;
		end else if (s.busy) begin
			next_s.tcnt = s.tcnt + TWR_W'(1);
			if (s.tcnt == TWR_LAST) begin
				next_s.busy = 1'b0;
			end
		end
		// standby once idle and no write in progress
		next_s.standby = ~fromlink_s[0] & ~next_s.busy;
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s         <= '0;
			s.standby <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// open drain: only ever drives zero
	assign sda_o      = l.drv;
	assign sda_oe_o   = l.oe;
	assign rx_data_o  = s.rx_data;
	assign rx_valid_o = s.rx_valid;
	assign busy_o     = s.busy;
	assign standby_o  = s.standby;

	sequence s_ack_fall;
		l.st == ETF_ACKW && fall_w && !start_w && !stop_w;
	endsequence

	sequence s_ack_held;
		sda_oe_o && l.st == ETF_ACK;
	endsequence

	chk_oe_on_fall: assert property (
		@(posedge link_clk_i) disable iff (!rstn_i)
		$changed(sda_oe_o)
		|-> $past(fall_w) || $past(start_w) || $past(stop_w))
		else $error("data line driven change outside clock low");
	chk_start_addr: assert property (
		@(posedge link_clk_i) disable iff (!rstn_i)
		start_w && !l.wbusy |=> l.st == ETF_ADDR && l.cnt == 4'h0)
		else $error("start not taken");
	chk_idle_quiet: assert property (
		@(posedge link_clk_i) disable iff (!rstn_i)
		l.st == ETF_IDLE && !start_w |=> l.st == ETF_IDLE && !sda_oe_o)
		else $error("idle left without start");
	chk_stop_idle: assert property (
		@(posedge link_clk_i) disable iff (!rstn_i)
		stop_w |=> l.st == ETF_IDLE && !sda_oe_o && l.cnt == 4'h0)
		else $error("stop not taken");
	// a poll stop may land inside a running write cycle: no new cycle only
	chk_read_stop: assert property (
		@(posedge link_clk_i) disable iff (!rstn_i)
		stop_w && !l.wseen |=> !l.act && !$rose(l.wbusy))
		else $error("read stop not idle");
	chk_ack_nine: assert property (
		@(posedge link_clk_i) disable iff (!rstn_i)
		s_ack_fall |=> s_ack_held)
		else $error("ninth clock not acknowledged");
	chk_mismatch: assert property (
		@(posedge link_clk_i) disable iff (!rstn_i)
		l.st == ETF_ADDR && rise_w && l.cnt == LAST_BIT && !match_w
		&& !start_w && !stop_w |=> l.st == ETF_IDLE ##1 !sda_oe_o)
		else $error("mismatched address answered");
	chk_read_sel: assert property (
		@(posedge link_clk_i) disable iff (!rstn_i)
		l.st == ETF_ACK && fall_w && l.rw && !start_w && !stop_w
		|=> l.st == ETF_RTX && sda_oe_o == ~l.sh[WORD_W-1])
		else $error("read select not honoured");
	chk_busy_noack: assert property (
		@(posedge link_clk_i) disable iff (!rstn_i)
		l.wbusy |-> !sda_oe_o && l.st == ETF_IDLE)
		else $error("answered during write cycle");
	chk_release: assert property (
		@(posedge link_clk_i) disable iff (!rstn_i)
		sda_oe_o |-> l.st inside {ETF_ACK, ETF_RTX, ETF_RACK})
		else $error("data line held outside its slots");
	chk_bit_count: assert property (
		@(posedge link_clk_i) disable iff (!rstn_i)
		start_w || stop_w |=> l.cnt == 4'h0 && l.cnt <= WORD_BITS)
		else $error("bit count not restarted");
	chk_standby: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		$rose(busy_o) |-> !standby_o ##1 busy_o[*8])
		else $error("standby during write cycle");
endmodule : etf_frontend

// *** hw/etf_unused.sv ***
// spare source file: holds no logic

// *** bench/etf_master.sv ***
// bus master model for the two-wire link
module etf_master (
	input  wire logic mclk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_low_o
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	// clock low spans more than five link cycles
	task automatic qtr();
		repeat (6) @(posedge mclk_i);
		#1;
	endtask : qtr
	task automatic start();
		sda_low_o = 1'b0;
		qtr();
		scl_o = 1'b1;
		qtr();
		sda_low_o = 1'b1;
		qtr();
		scl_o = 1'b0;
		qtr();
	endtask : start
	task automatic stop();
		sda_low_o = 1'b1;
		qtr();
		scl_o = 1'b1;
		qtr();
		sda_low_o = 1'b0;
		qtr();
	endtask : stop
	task automatic drop();
		scl_o = 1'b0;
		qtr();
	endtask : drop
	// data moves with clock low, only pulls low
	task automatic bit_io(input logic b, output logic r);
		sda_low_o = ~b;
		qtr();
		scl_o = 1'b1;
		qtr();
		r = sda_i;
		qtr();
		scl_o = 1'b0;
		qtr();
	endtask : bit_io
	// msb first, ninth clock carries the acknowledge
	task automatic xfer(input logic [7:0] d, input logic a,
		output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(a, ack);
	endtask : xfer
endmodule : etf_master

// *** bench/etf_frontend_tb.sv ***
// self-checking bench for the two-wire eeprom front end
module etf_frontend_tb
	import etf_pkg::*;
();
	timeunit 1ns;
	timeprecision 100ps;
	localparam int         TWR   = 400;
	localparam logic [2:0] STRAP = 3'h5;
	localparam logic [7:0] AW    = {DEV_TYPE, STRAP, 1'b0};
	localparam logic [7:0] AR    = {DEV_TYPE, STRAP, 1'b1};
	logic       mclk     = 1'b0;
	logic       link_clk = 1'b0;
	logic       rstn     = 1'b0;
	logic [7:0] tx_data  = 8'h00;
	logic       tx_load  = 1'b0;
	logic       scl, sda_low, sda, dut_sda, sda_oe, rx_valid, busy, standby;
	logic [7:0] rx_data, q;
	logic       ack;
	int         n_fail     = 0;
	int         n_compared = 0;
	int         rx_cnt     = 0;
	always #25 mclk = ~mclk;
	always #24 link_clk = ~link_clk;
	// pull-up: line high unless someone pulls low
	assign sda = ~(sda_low | (sda_oe & ~dut_sda));
	etf_frontend #(.TWR_CYCLES(TWR)) DUT (.mclk_i(mclk), .rstn_i(rstn),
		.link_clk_i(link_clk), .scl_i(scl), .sda_i(sda), .sda_o(dut_sda),
		.sda_oe_o(sda_oe), .chip_select_straps_i(STRAP),
		.tx_data_i(tx_data), .tx_load_i(tx_load), .rx_data_o(rx_data),
		.rx_valid_o(rx_valid), .busy_o(busy), .standby_o(standby));
	etf_master mst (.mclk_i(mclk), .sda_i(sda), .scl_o(scl),
		.sda_low_o(sda_low));
	always @(posedge mclk) if (rx_valid === 1'b1) rx_cnt++;
	task automatic check(input string nm, input logic [7:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic finish_test();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : finish_test
	// device moves the line only with clock low
	always @(sda_oe) begin
		if (rstn === 1'b1) check("oe_scl", 8'(scl), 8'h0);
		if (rstn === 1'b1) check("sda_o", 8'(dut_sda), 8'h0);
	end
	// sel 0 watches busy, 1 watches standby
	task automatic wait_for(input logic sel, lvl, input int lim);
		int i;
		i = 0;
		while (((sel ? standby : busy) !== lvl) && i < lim) begin
			@(posedge mclk);
			#1;
			i++;
		end
		if (i >= lim) begin
			n_fail++;
			$display("FAIL wait expected %0b seen timeout", lvl);
			finish_test();
		end
	endtask : wait_for
	task automatic load(input logic [7:0] d);
		tx_data = d;
		tx_load = 1'b1;
		@(posedge mclk);
		#1;
		tx_load = 1'b0;
	endtask : load
	task automatic t_reset();
		check("standby", 8'(standby), 8'h1);
		check("busy", 8'(busy), 8'h0);
		check("oe", 8'(sda_oe), 8'h0);
		check("rx_data", rx_data, 8'h00);
	endtask : t_reset
	// write, poll while busy, poll after
	task automatic t_write();
		int base;
		base = rx_cnt;
		mst.start();
		mst.xfer(AW, 1'b1, q, ack);
		check("addr_ack", 8'(ack), 8'h0);
		mst.xfer(8'h5a, 1'b1, q, ack);
		check("data_ack", 8'(ack), 8'h0);
		check("rx_data", rx_data, 8'h5a);
		check("rx_pulses", 8'(rx_cnt - base), 8'h01);
		mst.stop();
		wait_for(1'b0, 1'b1, 10);
		check("busy_standby", 8'(standby), 8'h0);
		mst.start();
		mst.xfer(AW, 1'b1, q, ack);
		check("poll_busy", 8'(ack), 8'h1);
		check("still_busy", 8'(busy), 8'h1);
		mst.stop();
		wait_for(1'b0, 1'b0, TWR);
		wait_for(1'b1, 1'b1, 10);
		mst.start();
		mst.xfer(AW, 1'b1, q, ack);
		check("poll_done", 8'(ack), 8'h0);
		mst.stop();
	endtask : t_write
	// every strap code, one wrong type code
	task automatic t_select();
		for (int s = 0; s < 9; s++) begin
			mst.start();
			if (s < 8) mst.xfer({DEV_TYPE, 3'(s), 1'b0}, 1'b1, q, ack);
			else mst.xfer({4'h5, STRAP, 1'b0}, 1'b1, q, ack);
			mst.stop();
			check("sel_ack", 8'(ack), 8'(s != STRAP));
			wait_for(1'b1, 1'b1, 10);
		end
	endtask : t_select
	// read twice then stop into standby
	task automatic t_read();
		load(8'h3c);
		mst.start();
		mst.xfer(AR, 1'b1, q, ack);
		check("rd_ack", 8'(ack), 8'h0);
		mst.xfer(8'hff, 1'b0, q, ack);
		check("rd_byte", q, 8'h3c);
		mst.xfer(8'hff, 1'b1, q, ack);
		check("rd_again", q, 8'h3c);
		mst.stop();
		wait_for(1'b1, 1'b1, 10);
		check("rd_free", 8'(sda), 8'h1);
		check("rd_no_wr", 8'(busy), 8'h0);
	endtask : t_read
	task automatic t_frame();
		mst.drop();
		mst.xfer(AW, 1'b1, q, ack);
		check("no_start", 8'(ack), 8'h1);
		mst.start();
		for (int i = 0; i < 4; i++) mst.bit_io(1'b1, ack);
		mst.start();
		mst.xfer(AW, 1'b1, q, ack);
		check("restart_ack", 8'(ack), 8'h0);
		mst.stop();
	endtask : t_frame
	// recovery clocks after an aborted read
	task automatic t_recover();
		load(8'h00);
		mst.start();
		mst.xfer(AR, 1'b1, q, ack);
		for (int i = 0; i < 3; i++) mst.bit_io(1'b1, ack);
		ack = 1'b0;
		for (int i = 0; i < 9 && ack !== 1'b1; i++) mst.bit_io(1'b1, ack);
		check("recover_high", 8'(ack), 8'h1);
		mst.start();
		mst.xfer(AW, 1'b1, q, ack);
		check("recover_ack", 8'(ack), 8'h0);
		mst.stop();
	endtask : t_recover
	initial begin
		repeat (8) @(posedge mclk);
		#1;
		rstn = 1'b1;
		@(posedge mclk);
		#1;
		check("standby_rel", 8'(standby), 8'h1);
		repeat (3) @(posedge mclk);
		#1;
		t_reset();
		t_write();
		t_select();
		t_read();
		t_frame();
		t_recover();
		finish_test();
	end
endmodule : etf_frontend_tb
